// ### hdl/arx_pkg.sv
/*
  Constants, types and helpers shared by the dual line receiver block.
  Assumes a single clock, with the sample and transmit rates made by enables.
*/
// Function
// R01: Ten-bit config word captured on strobe edge
// R02: Config bit 5 low loops transmitter into receivers
// R03: Receiver 1 filter matches bits 9, 10
// R04: Receiver 2 filter matches bits 9, 10
// R05: Config bit 12 picks transmit parity sense
// R06: Config bit 13 picks transmit divide 10/80
// R07: Config bit 14 picks receive divide 10/80
// R08: Byte 1 and byte 2 bus bit mapping
// R09: First bit on line is bit 1
// R10: Any out-of-window line state drops word
// R11: Ten-sample shift, three equal samples valid
// R12: Each bit followed by null within bit time
// R13: Gap null needs nulls in both halves
// R14: Bit spacing eight to twelve samples
// R15: Three gap nulls re-enable reception
// R16: Read bit 32 low when ones count odd
// R17: Word complete pulse after 32 bits
// R18: Complete pulse sets ready when filter passes
// R19: Ready stays low until both bytes read
// R20: Enables pick receiver, select picks byte
// R21: New word overwrites unread held word
// R22: Receiver 2 drives only while enable 1 high
// R23: Bytes may be read in either order
// R24: Master reset clears receivers, keeps config
// R25: Bus released when no enable is active
package arx_pkg;

  // Configuration word, bus bit of cfg[0] and field positions
  localparam int CFG_W          = 10;
  localparam int CFG_LSB        = 5;
  localparam int CFG_LOOPBACK_N = 0;
  localparam int CFG_RX1_FILT   = 1;
  localparam int CFG_RX1_M9     = 2;
  localparam int CFG_RX1_M10    = 3;
  localparam int CFG_RX2_FILT   = 4;
  localparam int CFG_RX2_M9     = 5;
  localparam int CFG_RX2_M10    = 6;
  localparam int CFG_TX_EVEN    = 7;
  localparam int CFG_TX_SLOW    = 8;
  localparam int CFG_RX_SLOW    = 9;
  localparam logic [9:0] CFG_RESET = 10'h001;

  // Synchroniser reset: master reset and read enables at their idle high level
  localparam logic [26:0] PIN_IDLE = 27'h4000180;

  // Clock dividers
  localparam logic [6:0] DIV_FAST_LAST = 7'h09;
  localparam logic [6:0] DIV_SLOW_LAST = 7'h4F;
  localparam logic [6:0] DIV_FAST_HALF = 7'h05;
  localparam logic [6:0] DIV_SLOW_HALF = 7'h28;

  // Sample timing
  localparam int SAMPLE_LEN            = 10;
  localparam logic [3:0] SPACE_MIN     = 4'h8;
  localparam logic [3:0] SPACE_MAX     = 4'hC;
  localparam logic [3:0] NULL_WAIT     = 4'hA;
  localparam logic [1:0] GAP_NULLS     = 2'h3;
  localparam logic [5:0] WORD_BITS     = 6'h20;

  // Word bit positions (serial bit n sits at index n-1)
  localparam int BIT9_IDX  = 8;
  localparam int BIT10_IDX = 9;
  localparam int PAR_IDX   = 31;

  typedef enum logic [1:0] {
    ST_GAP  = 2'b00,
    ST_IDLE = 2'b01,
    ST_NULL = 2'b10,
    ST_DATA = 2'b11
  } arx_state_t;

  // Label filter test
  function automatic logic filt_pass(input logic [31:0] w, input logic en, input logic m9, input logic m10);
    filt_pass = !en || ((w[BIT9_IDX] == m9) && (w[BIT10_IDX] == m10));
  endfunction

  // Word to bus byte
  function automatic logic [15:0] byte_map(input logic [31:0] w, input logic sel);
    if (sel)
      byte_map = w[28:13];
    else
      byte_map = {w[12:8], w[30], w[29], w[31],
                  w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
  endfunction

endpackage

// ### hdl/arx_clkdiv.sv
/*
  Divides the clock by 10 or 80: a one-cycle enable and a square wave.
  Assumes the select changes seldom; a change acts on the running count without restarting the period.
*/
`timescale 1ns/1ps
`default_nettype none
module arx_clkdiv (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic slow_i,
  // Outputs
  output var  logic tick_o,
  output var  logic wave_o
);

  logic [6:0] cnt;
  logic [6:0] last;
  logic [6:0] half;

  assign last = slow_i ? arx_pkg::DIV_SLOW_LAST : arx_pkg::DIV_FAST_LAST;
  assign half = slow_i ? arx_pkg::DIV_SLOW_HALF : arx_pkg::DIV_FAST_HALF;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt    <= 7'h00;
      tick_o <= 1'b0;
    end
    else if (cnt >= last)
    begin
      cnt    <= 7'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt    <= cnt + 7'h01;
      tick_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wave_o <= 1'b0;
    else
      wave_o <= (cnt < half);
  end

endmodule
`default_nettype wire

// ### hdl/arx_rx_core.sv
/*
  One serial receiver: sampling, pulse and spacing checks, word gap, parity.
  Assumes line states come from the same clock and tick_i is a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none
module arx_rx_core (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  // Line state
  input  wire logic        one_i,
  input  wire logic        zero_i,
  // Word out
  output var  logic [31:0] word_o,
  output var  logic        done_o
);

  arx_pkg::arx_state_t state;
  logic [arx_pkg::SAMPLE_LEN-1:0] one_sr;
  logic [arx_pkg::SAMPLE_LEN-1:0] zero_sr;
  logic [arx_pkg::SAMPLE_LEN-1:0] null_sr;
  logic [3:0]  space;
  logic [3:0]  next_space;
  logic [5:0]  bit_cnt;
  logic [1:0]  gap_cnt;
  logic [31:0] word;
  logic        v_one;
  logic        v_zero;
  logic        v_null;
  logic        gap_null;
  logic        bad;

  // Line state history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      one_sr  <= '0;
      zero_sr <= '0;
      null_sr <= '0;
    end
    else if (tick_i)
    begin
      one_sr  <= {one_sr[8:0], one_i & !zero_i};
      zero_sr <= {zero_sr[8:0], zero_i & !one_i};
      null_sr <= {null_sr[8:0], !one_i & !zero_i};
    end
  end

  assign v_one      = &one_sr[2:0]; // R11
  assign v_zero     = &zero_sr[2:0]; // R11
  assign v_null     = &null_sr[2:0]; // R11
  assign gap_null   = v_null && (&null_sr[9:7]); // R13
  assign bad        = one_i && zero_i; // R10
  assign next_space = space + 4'h1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state   <= arx_pkg::ST_GAP;
      space   <= 4'h0;
      bit_cnt <= 6'h00;
      gap_cnt <= 2'h0;
      word    <= '0;
      word_o  <= '0;
      done_o  <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (tick_i)
      begin
        case (state)
          arx_pkg::ST_GAP:
          begin
            if (gap_null)
            begin
              if (gap_cnt + 2'h1 == arx_pkg::GAP_NULLS) // R15
              begin
                state   <= arx_pkg::ST_IDLE;
                gap_cnt <= 2'h0;
              end
              else
                gap_cnt <= gap_cnt + 2'h1;
            end
            else
              gap_cnt <= 2'h0;
          end
          arx_pkg::ST_IDLE:
          begin
            if (v_one || v_zero)
            begin
              word[0] <= v_one; // R09
              bit_cnt <= 6'h01;
              space   <= 4'h0;
              state   <= arx_pkg::ST_NULL;
            end
          end
          arx_pkg::ST_NULL:
          begin
            space <= next_space;
            if (bad || (word[bit_cnt[4:0] - 5'h01] ? v_zero : v_one)) // R10
              state <= arx_pkg::ST_GAP;
            else if (v_null)
            begin
              if (bit_cnt == arx_pkg::WORD_BITS)
              begin
                word_o <= {~^word, word[30:0]}; // R16
                done_o <= 1'b1; // R17
                state  <= arx_pkg::ST_GAP;
              end
              else
                state <= arx_pkg::ST_DATA;
            end
            else if (next_space >= arx_pkg::NULL_WAIT) // R12
              state <= arx_pkg::ST_GAP;
          end
          arx_pkg::ST_DATA:
          begin
            space <= next_space;
            if (bad) // R10
              state <= arx_pkg::ST_GAP;
            else if (v_one || v_zero)
            begin
              if (next_space < arx_pkg::SPACE_MIN || next_space > arx_pkg::SPACE_MAX) // R14
                state <= arx_pkg::ST_GAP;
              else
              begin
                word[bit_cnt[4:0]] <= v_one; // R09
                bit_cnt            <= bit_cnt + 6'h01;
                space              <= 4'h0;
                state              <= arx_pkg::ST_NULL;
              end
            end
            else if (next_space > arx_pkg::SPACE_MAX) // R14
              state <= arx_pkg::ST_GAP;
          end
          default:
            state <= arx_pkg::ST_GAP;
        endcase
      end
    end
  end

  property p_space_min;
    @(posedge clk_i) disable iff (rst_i)
    (tick_i && state == arx_pkg::ST_DATA && !bad && (v_one || v_zero) && space < 4'h7) |=> state == arx_pkg::ST_GAP;
  endproperty
  a_space_min: assert property (p_space_min) else $error("bit accepted too early"); // R14

  property p_space_max;
    @(posedge clk_i) disable iff (rst_i)
    (tick_i && state == arx_pkg::ST_DATA && !bad && (v_one || v_zero) && space > 4'hB) |=> state == arx_pkg::ST_GAP;
  endproperty
  a_space_max: assert property (p_space_max) else $error("bit accepted too late"); // R14

  property p_null_wait;
    @(posedge clk_i) disable iff (rst_i)
    (tick_i && state == arx_pkg::ST_NULL && !v_null && space == 4'h9) |=> state == arx_pkg::ST_GAP;
  endproperty
  a_null_wait: assert property (p_null_wait) else $error("missing null not rejected"); // R12

  property p_parity;
    @(posedge clk_i) disable iff (rst_i)
    done_o |-> (word_o[31] ^ (^word)) == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong"); // R16

endmodule
`default_nettype wire

// ### hdl/arx_top.sv
/*
  Dual receiver with configuration word, loopback, held words and byte readout.
  Assumes all pins other than RST_I are asynchronous to CLOCK_I; bus data settles before the
  configuration strobe rises and the read enables are held for several cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module arx_top (
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        MASTER_RESET_N_I,
  // Host bus
  input  wire logic        CONFIG_WRITE_STROBE_I,
  input  wire logic        RX1_READ_ENABLE_N_I,
  input  wire logic        RX2_READ_ENABLE_N_I,
  input  wire logic        BYTE_SELECT_I,
  input  wire logic [15:0] BUS_DATA_I,
  output var  logic [15:0] BUS_DATA_O,
  output var  logic        BUS_DATA_OE_O,
  // Receiver line comparators
  input  wire logic        RX1_LINE_ONE_I,
  input  wire logic        RX1_LINE_ZERO_I,
  input  wire logic        RX2_LINE_ONE_I,
  input  wire logic        RX2_LINE_ZERO_I,
  // Transmitter digital outputs for self test
  input  wire logic        TX_LINE_ONE_I,
  input  wire logic        TX_LINE_ZERO_I,
  // Ready flags
  output var  logic        RX1_WORD_READY_N_O,
  output var  logic        RX2_WORD_READY_N_O,
  // Transmitter settings
  output var  logic        CFG_TX_EVEN_PARITY_O,
  output var  logic        CFG_TX_SLOW_CLOCK_O,
  output var  logic        TX_DATA_CLOCK_O,
  output var  logic        TX_DATA_TICK_O
);

  localparam int PIN_W = 27;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic             mr;
  logic             stb_s;
  logic             stb_d;
  logic             cfg_rise;
  logic [15:0]      bus_s;
  logic [1:0]       en_n_s;
  logic             sel_s;
  logic [1:0]       line_one_s;
  logic [1:0]       line_zero_s;
  logic             tx_one_s;
  logic             tx_zero_s;

  logic [arx_pkg::CFG_W-1:0] cfg;

  logic [1:0]       rx_one;
  logic [1:0]       rx_zero;
  logic             rx_rst;
  logic             sample_tick;
  logic [31:0]      rx_word [2];
  logic [1:0]       rx_done;
  logic [1:0]       accept;
  logic [31:0]      hold [2];
  logic [1:0]       rdy_n;
  logic [1:0]       rd_b1;
  logic [1:0]       rd_b2;
  logic [1:0]       en_act;
  logic [1:0]       filt_en;
  logic [1:0]       m9;
  logic [1:0]       m10;

  // Two-stage synchronisers for every input pin except CLOCK_I and RST_I
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      pin_meta <= arx_pkg::PIN_IDLE;
      pin_sync <= arx_pkg::PIN_IDLE;
    end
    else
    begin
      pin_meta <= {MASTER_RESET_N_I, CONFIG_WRITE_STROBE_I, BUS_DATA_I,
                   RX2_READ_ENABLE_N_I, RX1_READ_ENABLE_N_I, BYTE_SELECT_I,
                   RX2_LINE_ONE_I, RX1_LINE_ONE_I, RX2_LINE_ZERO_I, RX1_LINE_ZERO_I,
                   TX_LINE_ONE_I, TX_LINE_ZERO_I};
      pin_sync <= pin_meta;
    end
  end

  assign mr          = !pin_sync[26];
  assign stb_s       = pin_sync[25];
  assign bus_s       = pin_sync[24:9];
  assign en_n_s      = pin_sync[8:7];
  assign sel_s       = pin_sync[6];
  assign line_one_s  = pin_sync[5:4];
  assign line_zero_s = pin_sync[3:2];
  assign tx_one_s    = pin_sync[1];
  assign tx_zero_s   = pin_sync[0];

  // Configuration word; master reset leaves it alone
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      stb_d <= 1'b0;
    else
      stb_d <= stb_s;
  end

  assign cfg_rise = stb_s && !stb_d;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      cfg <= arx_pkg::CFG_RESET;
    else if (cfg_rise)
      cfg <= bus_s[arx_pkg::CFG_LSB +: arx_pkg::CFG_W]; // R01
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      CFG_TX_EVEN_PARITY_O <= 1'b0;
      CFG_TX_SLOW_CLOCK_O  <= 1'b0;
    end
    else
    begin
      CFG_TX_EVEN_PARITY_O <= cfg[arx_pkg::CFG_TX_EVEN]; // R05
      CFG_TX_SLOW_CLOCK_O  <= cfg[arx_pkg::CFG_TX_SLOW];
    end
  end

  // Self test: receiver 1 sees the transmitter, receiver 2 its complement
  always_comb
  begin
    if (!cfg[arx_pkg::CFG_LOOPBACK_N]) // R02
    begin
      rx_one  = {tx_zero_s, tx_one_s};
      rx_zero = {tx_one_s, tx_zero_s};
    end
    else
    begin
      rx_one  = line_one_s;
      rx_zero = line_zero_s;
    end
  end

  // Rate enables
  arx_clkdiv u_tx_div (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .slow_i (cfg[arx_pkg::CFG_TX_SLOW]), // R06
    .tick_o (TX_DATA_TICK_O),
    .wave_o (TX_DATA_CLOCK_O)
  );

  arx_clkdiv u_rx_div (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .slow_i (cfg[arx_pkg::CFG_RX_SLOW]), // R07
    .tick_o (sample_tick),
    .wave_o ()
  );

  assign rx_rst = RST_I || mr; // R24

  assign filt_en = {cfg[arx_pkg::CFG_RX2_FILT], cfg[arx_pkg::CFG_RX1_FILT]};
  assign m9      = {cfg[arx_pkg::CFG_RX2_M9], cfg[arx_pkg::CFG_RX1_M9]};
  assign m10     = {cfg[arx_pkg::CFG_RX2_M10], cfg[arx_pkg::CFG_RX1_M10]};

  // Receiver 2 is seen only while enable 1 is idle
  assign en_act[0] = !en_n_s[0]; // R20
  assign en_act[1] = !en_n_s[1] && en_n_s[0]; // R22

  for (genvar i = 0; i < 2; i++)
  begin : g_rx
    arx_rx_core u_core (
      .clk_i  (CLOCK_I),
      .rst_i  (rx_rst),
      .tick_i (sample_tick),
      .one_i  (rx_one[i]),
      .zero_i (rx_zero[i]),
      .word_o (rx_word[i]),
      .done_o (rx_done[i])
    );

    assign accept[i] = rx_done[i] && arx_pkg::filt_pass(rx_word[i], filt_en[i], m9[i], m10[i]); // R03 R04 R18

  end

  // Held words, ready flags and byte-read tracking
  always_ff @(posedge CLOCK_I)
  begin
    for (int k = 0; k < 2; k++)
    begin
      if (rx_rst)
      begin
        hold[k]  <= '0;
        rdy_n[k] <= 1'b1;
        rd_b1[k] <= 1'b0;
        rd_b2[k] <= 1'b0;
      end
      else if (accept[k])
      begin
        hold[k]  <= rx_word[k]; // R21
        rdy_n[k] <= 1'b0; // R18
        rd_b1[k] <= 1'b0;
        rd_b2[k] <= 1'b0;
      end
      else if ((rd_b1[k] || (en_act[k] && !sel_s)) && (rd_b2[k] || (en_act[k] && sel_s))) // R19 R23
      begin
        rdy_n[k] <= 1'b1;
        rd_b1[k] <= 1'b0;
        rd_b2[k] <= 1'b0;
      end
      else if (en_act[k])
      begin
        rd_b1[k] <= rd_b1[k] || !sel_s; // R23
        rd_b2[k] <= rd_b2[k] || sel_s;
      end
    end
  end

  assign RX1_WORD_READY_N_O = rdy_n[0];
  assign RX2_WORD_READY_N_O = rdy_n[1];

  // Bus readout
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      BUS_DATA_O    <= 16'h0000;
      BUS_DATA_OE_O <= 1'b0;
    end
    else
    begin
      BUS_DATA_OE_O <= |en_act; // R25
      if (en_act[0])
        BUS_DATA_O <= arx_pkg::byte_map(hold[0], sel_s); // R08
      else if (en_act[1])
        BUS_DATA_O <= arx_pkg::byte_map(hold[1], sel_s); // R08
      else
        BUS_DATA_O <= 16'h0000;
    end
  end

  property p_cfg_capture;
    @(posedge CLOCK_I) disable iff (RST_I)
    cfg_rise |=> cfg == $past(bus_s[14:5]);
  endproperty
  a_cfg_capture: assert property (p_cfg_capture) else $error("config not captured"); // R01

  property p_filter1;
    @(posedge CLOCK_I) disable iff (RST_I)
    (rx_done[0] && cfg[1] && (rx_word[0][8] != cfg[2] || rx_word[0][9] != cfg[3]) && !mr) |=> $stable(hold[0]);
  endproperty
  a_filter1: assert property (p_filter1) else $error("receiver 1 filter leaked word"); // R03

  property p_filter2;
    @(posedge CLOCK_I) disable iff (RST_I)
    (rx_done[1] && cfg[4] && (rx_word[1][8] != cfg[5] || rx_word[1][9] != cfg[6]) && !mr) |=> $stable(hold[1]);
  endproperty
  a_filter2: assert property (p_filter2) else $error("receiver 2 filter leaked word"); // R04

  property p_ready_set;
    @(posedge CLOCK_I) disable iff (RST_I)
    (accept[0] && !mr) |=> !RX1_WORD_READY_N_O ##1 !RX1_WORD_READY_N_O;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set by word"); // R18

  property p_ready_hold;
    @(posedge CLOCK_I) disable iff (RST_I)
    (!rdy_n[1] && !rd_b2[1] && !(en_act[1] && sel_s) && !mr) |=> !RX2_WORD_READY_N_O;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready cleared before both bytes"); // R19

  property p_overwrite;
    @(posedge CLOCK_I) disable iff (RST_I)
    (accept[1] && !mr) |=> hold[1] == $past(rx_word[1]);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("new word not stored"); // R21

  property p_rx2_gate;
    @(posedge CLOCK_I) disable iff (RST_I)
    !en_n_s[0] |=> BUS_DATA_O == arx_pkg::byte_map($past(hold[0]), $past(sel_s)) && BUS_DATA_OE_O;
  endproperty
  a_rx2_gate: assert property (p_rx2_gate) else $error("receiver 1 not on bus"); // R22

  property p_mr;
    @(posedge CLOCK_I) disable iff (RST_I)
    (mr && !cfg_rise) |=> (rdy_n == 2'h3) && $stable(cfg);
  endproperty
  a_mr: assert property (p_mr) else $error("master reset effect wrong"); // R24

  property p_release;
    @(posedge CLOCK_I) disable iff (RST_I)
    (en_n_s == 2'h3) |=> !BUS_DATA_OE_O;
  endproperty
  a_release: assert property (p_release) else $error("bus not released"); // R25

  property p_rx2_read;
    @(posedge CLOCK_I) disable iff (RST_I)
    en_act[1] |=> BUS_DATA_O == arx_pkg::byte_map($past(hold[1]), $past(sel_s)) && BUS_DATA_OE_O;
  endproperty
  a_rx2_read: assert property (p_rx2_read) else $error("receiver 2 not on bus"); // R20

  property p_ready_clear;
    @(posedge CLOCK_I) disable iff (RST_I)
    (!rdy_n[0] && rd_b1[0] && en_act[0] && sel_s && !accept[0] && !mr) |=> RX1_WORD_READY_N_O;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared after both bytes"); // R23

endmodule
`default_nettype wire

// ### dv/arx_line_model.sv
/*
  Behavioural line transmitter: drives comparator one/zero levels for one word.
  Assumes it is driven by the bench clock; the line idles at null between words.
*/
`timescale 1ns/1ps
`default_nettype none
module arx_line_model (
  // Clock
  input  wire logic clk_i,
  // Comparator levels
  output var  logic one_o,
  output var  logic zero_o
);
  // Per bit: level for hi clocks, then null; bad marks a both-high bit
  task automatic send(input logic [31:0] w, input int per, input int hi, input int bad);
    repeat (200) @(negedge clk_i);
    for (int b = 0; b < 32; b++)
    begin
      one_o  = w[b] || (b == bad);
      zero_o = !w[b] || (b == bad);
      repeat (hi) @(negedge clk_i);
      one_o  = 1'b0;
      zero_o = 1'b0;
      repeat (per - hi) @(negedge clk_i);
    end
    repeat (200) @(negedge clk_i);
  endtask

  initial
  begin
    one_o  = 1'b0;
    zero_o = 1'b0;
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
/*
  Self-checking bench for the dual line receiver top.
  Assumes two line models; the second also feeds the transmitter self-test inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    logic [9:0]  cfg;
    logic [31:0] w1;
    logic [31:0] w2;
    logic        r1;
    logic        r2;
  } arx_row_t;

  logic        clk;
  logic        rst;
  logic        mr_n;
  logic        strobe;
  logic        en1_n;
  logic        en2_n;
  logic        sel;
  logic [15:0] din;
  logic [15:0] dout;
  logic        oe;
  logic        l1_one;
  logic        l1_zero;
  logic        l2_one;
  logic        l2_zero;
  logic        r1_n;
  logic        r2_n;
  logic        tx_even;
  logic        tx_slow;
  logic        tx_clk;
  logic        tx_tick;
  int          bad_count;
  int          tests_run;
  int          cycles;
  int          n;
  int          h;
  logic [15:0] d1;
  logic [15:0] d2;

  arx_row_t rows[5] = '{
    '{10'h001, 32'hFFFFFFFF, 32'h00000000, 1'b1, 1'b1},
    '{10'h0FB, 32'h12345678, 32'h0F0F0F0F, 1'b1, 1'b1},
    '{10'h117, 32'h12345678, 32'h0F0F0F0F, 1'b0, 1'b0},
    '{10'h19B, 32'h12345678, 32'h0F0F0F0F, 1'b1, 1'b0},
    '{10'h077, 32'h12345678, 32'h0F0F0F0F, 1'b0, 1'b1}};
  // Line timing cases: period, level clocks, bad bit, accepted
  int lines[7][4] = '{'{70, 35, -1, 0}, '{130, 65, -1, 0}, '{100, 50, 5, 0}, '{100, 100, -1, 0},
                      '{100, 20, -1, 0}, '{80, 40, -1, 1}, '{120, 60, -1, 1}};

  arx_top i_dut (
    .CLOCK_I               (clk),
    .RST_I                 (rst),
    .MASTER_RESET_N_I      (mr_n),
    .CONFIG_WRITE_STROBE_I (strobe),
    .RX1_READ_ENABLE_N_I   (en1_n),
    .RX2_READ_ENABLE_N_I   (en2_n),
    .BYTE_SELECT_I         (sel),
    .BUS_DATA_I            (din),
    .BUS_DATA_O            (dout),
    .BUS_DATA_OE_O         (oe),
    .RX1_LINE_ONE_I        (l1_one),
    .RX1_LINE_ZERO_I       (l1_zero),
    .RX2_LINE_ONE_I        (l2_one),
    .RX2_LINE_ZERO_I       (l2_zero),
    .TX_LINE_ONE_I         (l2_one),
    .TX_LINE_ZERO_I        (l2_zero),
    .RX1_WORD_READY_N_O    (r1_n),
    .RX2_WORD_READY_N_O    (r2_n),
    .CFG_TX_EVEN_PARITY_O  (tx_even),
    .CFG_TX_SLOW_CLOCK_O   (tx_slow),
    .TX_DATA_CLOCK_O       (tx_clk),
    .TX_DATA_TICK_O        (tx_tick)
  );

  arx_line_model m1 (.clk_i(clk), .one_o(l1_one), .zero_o(l1_zero));
  arx_line_model m2 (.clk_i(clk), .one_o(l2_one), .zero_o(l2_zero));

  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Both bus bytes; read bit 32 is 1 for an even ones count
  function automatic logic [31:0] exp_bytes(input logic [31:0] w);
    exp_bytes = {w[12:8], w[30], w[29], ~^w,
                 w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7], w[28:13]};
  endfunction

  task automatic wr_cfg(input logic [9:0] c);
    din = {1'b0, c, 5'h00};
    repeat (4) @(negedge clk);
    strobe = 1'b1;
    repeat (5) @(negedge clk);
    strobe = 1'b0;
    repeat (5) @(negedge clk);
  endtask

  task automatic rd(input logic [1:0] en, input logic s, output logic [15:0] d);
    sel = s;
    {en2_n, en1_n} = ~en;
    repeat (5) @(negedge clk);
    d = dout;
    check("bus enable", 1, oe);
    {en2_n, en1_n} = 2'b11;
    repeat (5) @(negedge clk);
    check("bus release", 0, oe);
  endtask

  task automatic rd_word(input logic [1:0] en, input logic [31:0] w);
    logic [15:0] b1;
    logic [15:0] b2;
    rd(en, 1'b0, b1);
    rd(en, 1'b1, b2);
    check("word bytes", exp_bytes(w), {b1, b2});
    check("ready after read", 1, en[0] ? r1_n : r2_n);
  endtask

  // Clocks between transmit ticks, and clocks with the transmit clock high
  task automatic tick_gap(output int g, output int h);
    g = 0;
    h = 0;
    while (tx_tick !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    while (tx_tick !== 1'b1 && g < 200)
    begin
      g++;
      h += tx_clk;
      @(negedge clk);
    end
    g++;
    h += tx_clk;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      bad_count++;
      finish_test();
    end
  end

  initial
  begin
    {bad_count, tests_run, cycles} = '0;
    {rst, mr_n, strobe, en1_n, en2_n, sel, din} = {5'b11011, 17'h00000};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (200) @(negedge clk);
    check("reset ready1", 1, r1_n);
    check("reset ready2", 1, r2_n);
    check("reset bus", 0, oe);
    check("reset tx cfg", 0, {tx_even, tx_slow});
    foreach (rows[i])
    begin
      wr_cfg(rows[i].cfg);
      check("tx parity sel", rows[i].cfg[7], tx_even);
      check("tx slow sel", rows[i].cfg[8], tx_slow);
      tick_gap(n, h);
      check("tx tick period", rows[i].cfg[8] ? 80 : 10, n);
      check("tx clock duty", rows[i].cfg[8] ? 40 : 5, h);
      fork
        m1.send(rows[i].w1, 100, 50, -1);
        m2.send(rows[i].w2, 100, 50, -1);
      join
      check("ready1", !rows[i].r1, r1_n);
      check("ready2", !rows[i].r2, r2_n);
      if (rows[i].r1)
        rd_word(2'b01, rows[i].w1);
      if (rows[i].r2)
        rd_word(2'b10, rows[i].w2);
    end
    wr_cfg(10'h001);
    foreach (lines[i])
    begin
      m1.send(32'hC3C3C3C3 ^ i, lines[i][0], lines[i][1], lines[i][2]);
      check("line timing", !lines[i][3], r1_n);
      if (lines[i][3])
        rd_word(2'b01, 32'hC3C3C3C3 ^ i);
    end
    // Unread word replaced, then bytes read in reverse order
    m1.send(32'hA5A5A5A5, 100, 50, -1);
    m1.send(32'h5A5A5A5B, 100, 50, -1);
    rd(2'b01, 1'b1, d2);
    check("ready after one byte", 0, r1_n);
    rd(2'b01, 1'b0, d1);
    check("overwritten word", exp_bytes(32'h5A5A5A5B), {d1, d2});
    check("ready after both", 1, r1_n);
    // Both enables low: receiver 1 owns the bus
    fork
      m1.send(32'h00FF00FF, 100, 50, -1);
      m2.send(32'h13579BDF, 100, 50, -1);
    join
    rd(2'b11, 1'b0, d1);
    check("enable priority", exp_bytes(32'h00FF00FF) >> 16, d1);
    check("rx2 not read", 0, r2_n);
    rd_word(2'b01, 32'h00FF00FF);
    rd_word(2'b10, 32'h13579BDF);
    // Self test: receiver 2 sees the complement
    wr_cfg(10'h000);
    m2.send(32'h2468ACE1, 100, 50, -1);
    rd_word(2'b01, 32'h2468ACE1);
    rd_word(2'b10, ~32'h2468ACE1);
    // Slow sampling rejects a fast word
    wr_cfg(10'h201);
    m1.send(32'h11112222, 100, 50, -1);
    check("slow sampling", 1, r1_n);
    wr_cfg(10'h181);
    m1.send(32'h33334444, 100, 50, -1);
    check("ready before master reset", 0, r1_n);
    mr_n = 1'b0;
    repeat (6) @(negedge clk);
    mr_n = 1'b1;
    repeat (6) @(negedge clk);
    check("ready after master reset", 1, r1_n);
    check("config kept", 2'b11, {tx_even, tx_slow});
    finish_test();
  end
endmodule
`default_nettype wire
